// File: core/ufc_ctrl.sv
// ufc_ctrl: host register file for port enables, flow mode, resume/pause
// characters and the read-clear error flags, plus the gating that follows.
// assumes: receiver and transmitter engines on clk_i give one-cycle event
// pulses and levels; the register port is a simple 16-bit synchronous port.
`timescale 1ns/1ps
`default_nettype none

// Function
// [RQ1] enable register: bit1 receiver, bit0 transmitter, both reset off
// [RQ2] host disables both directions before writing most port registers
// [RQ3] host writes the flow register only while the port is disabled
// [RQ4] half-duplex bit 3 drops received data while transmitting
// [RQ5] flow mode 000 none, 001 hardware handshake, 010 software characters
// [RQ6] mode 011 gates receive on address match, 100 gates both; 101-111 reserved
// [RQ7] software mode resumes sending on the resume character, reset 0x11
// [RQ8] software mode pauses sending on the pause character, reset 0x13
// [RQ9] characters compared at configured width; nine-bit mode forces bit 8 zero
// [RQ10] multidrop uses resume character as unicast, pause as multicast address
// [RQ11] error flags accumulate; a read clears bits 6 down to 3
// [RQ12] bit 7 shows live break, read-only, never cleared by reading
// [RQ13] overrun bit 6 sets when a byte arrives with receive FIFO full
// [RQ14] parity bit 5 sets on parity failure and holds until read
// [RQ15] framing bit 4 sets when a stop bit is missing
// [RQ16] break bit 3 latches on break and clears only on read
// [RQ17] flags are not tied to characters; wide mode gives per-character errors
// [RQ18] host writes zero to unused bits; device reads them as zero
// [RQ19] read returns pre-read flags; same-cycle error stays latched
module ufc_ctrl (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [9:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire logic [1:0] char_width_i,
	input wire logic nine_bit_i,
	input wire logic rx_char_valid_i,
	input wire logic [8:0] rx_char_i,
	input wire logic rx_fifo_full_i,
	input wire logic parity_err_i,
	input wire logic frame_err_i,
	input wire logic break_live_i,
	input wire logic tx_busy_i,
	output logic tx_enable_o,
	output logic rx_enable_o,
	output logic [2:0] flow_mode_o,
	output logic hw_flow_o,
	output logic tx_allow_o,
	output logic rx_accept_o,
	output logic rx_push_o,
	output logic overrun_o
);
	logic [1:0] port_enable;
	logic [3:0] flow_mode_select;
	logic [7:0] resume_char_unicast_addr;
	logic [7:0] pause_char_multicast_addr;
	logic [3:0] err_flags;
	logic break_sync1;
	logic break_sync2;
	logic sw_paused;
	logic addr_open;
	logic rx_char_d;
	logic addr_bit_d;
	logic match_resume;
	logic match_pause;

	wire sel_en = reg_addr_i == ufc_pkg::ADDR_PORT_ENABLE;
	wire sel_flow = reg_addr_i == ufc_pkg::ADDR_FLOW_MODE;
	wire sel_resume = reg_addr_i == ufc_pkg::ADDR_RESUME_CHAR;
	wire sel_pause = reg_addr_i == ufc_pkg::ADDR_PAUSE_CHAR;
	wire sel_err = reg_addr_i == ufc_pkg::ADDR_ERROR_FLAGS;
	wire [2:0] mode = flow_mode_select[2:0];
	wire is_sw = mode == ufc_pkg::UFC_FLOW_SW;
	wire is_drop_rx = mode == ufc_pkg::UFC_FLOW_DROP_RX;
	wire is_drop_rxtx = mode == ufc_pkg::UFC_FLOW_DROP_RXTX;
	wire is_drop = is_drop_rx || is_drop_rxtx;
	// [RQ4] half duplex: receiver deaf while the transmitter is busy
	wire rx_gate = port_enable[ufc_pkg::EN_RX_BIT]
		&& !(flow_mode_select[ufc_pkg::HALF_DUPLEX_BIT] && tx_busy_i);
	wire rx_taken = rx_char_valid_i && rx_gate;
	// in multidrop the ninth bit flags an address character
	wire addr_char = is_drop && nine_bit_i && rx_char_i[8];
	wire clr_err = reg_rd_i && sel_err;
	wire overrun_evt = rx_taken && !addr_char && rx_fifo_full_i;
	wire [3:0] err_events = {overrun_evt, rx_taken && parity_err_i,
		rx_taken && frame_err_i, break_sync2};
	// [RQ11] [RQ19] set wins over the read-clear in the same cycle
	wire [3:0] next_err = (clr_err ? 4'h0 : err_flags) | err_events;
	// [RQ12] [RQ18] live break in bit 7, reserved bits read zero
	wire [15:0] err_word = {8'h00, break_sync2, err_flags, 3'h0};
	wire [15:0] rd_mux = sel_en ? {14'h0000, port_enable}
		: sel_flow ? {12'h000, flow_mode_select}
		: sel_resume ? {8'h00, resume_char_unicast_addr}
		: sel_pause ? {8'h00, pause_char_multicast_addr}
		: sel_err ? err_word
		: 16'h0000;
	// [RQ6] data passes in address-gated modes only once addressed
	wire data_ok = !is_drop || addr_open;
	// [RQ5] [RQ6] [RQ7] [RQ8] transmit permission by mode
	wire next_tx_allow = port_enable[ufc_pkg::EN_TX_BIT]
		&& !(is_sw && sw_paused) && !(is_drop_rxtx && !addr_open);

	// [RQ9] registered comparison of the received character, one per address
	ufc_char_match u_match_resume (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.char_i(rx_char_i),
		.ref_i(resume_char_unicast_addr),
		.width_sel_i(char_width_i),
		.nine_bit_i(nine_bit_i && !is_drop),
		.match_o(match_resume)
	);
	ufc_char_match u_match_pause (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.char_i(rx_char_i),
		.ref_i(pause_char_multicast_addr),
		.width_sel_i(char_width_i),
		.nine_bit_i(nine_bit_i && !is_drop),
		.match_o(match_pause)
	);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			port_enable <= ufc_pkg::PORT_ENABLE_RST;
			flow_mode_select <= ufc_pkg::FLOW_MODE_RST;
			resume_char_unicast_addr <= ufc_pkg::RESUME_CHAR_RST;
			pause_char_multicast_addr <= ufc_pkg::PAUSE_CHAR_RST;
		end
		else if (reg_wr_i)
		begin
			// [RQ1]
			if (sel_en)
				port_enable <= reg_wdata_i[1:0];
			// [RQ3] written as given; reserved codes simply gate nothing
			if (sel_flow)
				flow_mode_select <= reg_wdata_i[3:0];
			if (sel_resume)
				resume_char_unicast_addr <= reg_wdata_i[7:0];
			if (sel_pause)
				pause_char_multicast_addr <= reg_wdata_i[7:0];
		end
	end

	// break pin level comes from the line side; two flops before use
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			break_sync1 <= 1'b0;
			break_sync2 <= 1'b0;
			err_flags <= ufc_pkg::ERROR_FLAGS_RST;
		end
		else
		begin
			break_sync1 <= break_live_i;
			break_sync2 <= break_sync1;
			// [RQ13] [RQ14] [RQ15] [RQ16] [RQ17]
			err_flags <= next_err;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rx_char_d <= 1'b0;
			addr_bit_d <= 1'b0;
		end
		else
		begin
			rx_char_d <= rx_taken;
			addr_bit_d <= addr_char;
		end
	end

	// matches are registered, so flow state acts one cycle after the char
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !port_enable[ufc_pkg::EN_RX_BIT])
		begin
			sw_paused <= 1'b0;
			addr_open <= 1'b0;
		end
		else if (rx_char_d)
		begin
			// [RQ7] [RQ8]
			if (is_sw && match_pause)
				sw_paused <= 1'b1;
			else if (is_sw && match_resume)
				sw_paused <= 1'b0;
			// [RQ10] unicast or multicast address opens, other address closes
			if (is_drop && addr_bit_d)
				addr_open <= match_resume || match_pause;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			reg_rdata_o <= 16'h0000;
			reg_rvalid_o <= 1'b0;
			tx_enable_o <= 1'b0;
			rx_enable_o <= 1'b0;
			flow_mode_o <= 3'h0;
			hw_flow_o <= 1'b0;
			tx_allow_o <= 1'b0;
			rx_accept_o <= 1'b0;
			rx_push_o <= 1'b0;
			overrun_o <= 1'b0;
		end
		else
		begin
			// [RQ19] data reflect flags before the clearing read
			reg_rdata_o <= reg_rd_i ? rd_mux : 16'h0000;
			reg_rvalid_o <= reg_rd_i;
			tx_enable_o <= port_enable[ufc_pkg::EN_TX_BIT];
			rx_enable_o <= port_enable[ufc_pkg::EN_RX_BIT];
			flow_mode_o <= mode;
			// [RQ5]
			hw_flow_o <= mode == ufc_pkg::UFC_FLOW_HW;
			tx_allow_o <= next_tx_allow;
			rx_accept_o <= rx_gate && data_ok;
			// [RQ6] address characters never enter the receive FIFO
			rx_push_o <= rx_taken && !addr_char && data_ok && !rx_fifo_full_i;
			overrun_o <= overrun_evt;
		end
	end

	a_err_read_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ11]
		clr_err && !(|err_events) |=> err_flags == 4'h0)
		else $error("error flags not cleared by read");
	a_err_sticky_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ14]
		$past(err_flags[2]) && !$past(clr_err) |-> err_flags[2])
		else $error("parity flag dropped without read");
	a_overrun_set_wins: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ19]
		overrun_evt && clr_err |=> err_flags[3])
		else $error("overrun lost on same-cycle read");
	a_break_live_read: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ12]
		reg_rd_i && sel_err |=> reg_rdata_o[7] == $past(break_sync2))
		else $error("live break bit wrong");
	a_enable_reset_off: assert property (@(posedge clk_i) // [RQ1]
		$past(rst_i) |-> !tx_enable_o && !rx_enable_o)
		else $error("enables not off after reset");
	a_half_duplex_drop: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ4]
		flow_mode_select[3] && tx_busy_i |=> !rx_push_o)
		else $error("data accepted during half-duplex transmit");
	a_sw_pause_stop: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ8]
		is_sw && sw_paused |=> !tx_allow_o)
		else $error("transmit allowed while paused");
	a_drop_tx_gate: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
		is_drop_rxtx && !addr_open |=> !tx_allow_o)
		else $error("transmit allowed without address match");
	a_frame_flag_set: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ15]
		rx_taken && frame_err_i |=> err_flags[1])
		else $error("framing flag not set");
	// gating, flag and read-back checks that the bench reaches only in part
	a_tx_off_block: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ1]
		!port_enable[ufc_pkg::EN_TX_BIT] |=> !tx_allow_o)
		else $error("transmit allowed while transmitter disabled");
	a_rx_off_block: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ1]
		!port_enable[ufc_pkg::EN_RX_BIT] |=> !rx_push_o && !rx_accept_o)
		else $error("receive accepted while receiver disabled");
	a_hw_flow_code: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ5]
		mode == ufc_pkg::UFC_FLOW_HW |=> hw_flow_o)
		else $error("hardware flow mode not flagged");
	a_drop_rx_gate: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
		is_drop && !addr_open |=> !rx_push_o)
		else $error("data pushed without address match");
	a_addr_not_pushed: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
		addr_char |=> !rx_push_o)
		else $error("address character pushed");
	a_sw_resume_clr: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ7]
		rx_char_d && is_sw && match_resume && !match_pause |=> !sw_paused)
		else $error("resume character did not release pause");
	a_sw_pause_set: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ8]
		rx_char_d && is_sw && match_pause && port_enable[ufc_pkg::EN_RX_BIT] |=> sw_paused)
		else $error("pause character did not pause");
	a_addr_open_match: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ10]
		rx_char_d && is_drop && addr_bit_d && (match_resume || match_pause)
			&& port_enable[ufc_pkg::EN_RX_BIT] |=> addr_open)
		else $error("matching address did not open");
	a_overrun_flag_set: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ13]
		overrun_evt |=> err_flags[3] && overrun_o)
		else $error("overrun not flagged");
	a_full_no_push: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ13]
		rx_fifo_full_i |=> !rx_push_o)
		else $error("push while receive buffer full");
	a_parity_flag_set: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ14]
		rx_taken && parity_err_i |=> err_flags[2])
		else $error("parity flag not set");
	a_break_flag_latch: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ16]
		break_sync2 |=> err_flags[0])
		else $error("break flag not latched");
	a_break_sticky_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ16]
		$past(err_flags[0]) && !$past(clr_err) |-> err_flags[0])
		else $error("break flag dropped without read");
	a_reserved_read_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ18]
		reg_rd_i |=> reg_rdata_o[15:8] == 8'h00)
		else $error("reserved bits not zero on read");
	a_err_read_value: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ19]
		clr_err |=> reg_rdata_o[6:3] == $past(err_flags))
		else $error("read did not return flags before clear");
endmodule : ufc_ctrl
`default_nettype wire

// File: core/ufc_pkg.sv
// ufc_pkg: register map, field positions, reset values and mode codes of the
// serial-port control and error-status block.
// assumes: a 16-bit register port driven by the bridge core on clk_i.
package ufc_pkg;
	localparam logic [9:0] ADDR_PORT_ENABLE = 10'h000;
	localparam logic [9:0] ADDR_FLOW_MODE = 10'h006;
	localparam logic [9:0] ADDR_RESUME_CHAR = 10'h007;
	localparam logic [9:0] ADDR_PAUSE_CHAR = 10'h008;
	localparam logic [9:0] ADDR_ERROR_FLAGS = 10'h009;

	localparam int EN_TX_BIT = 0;
	localparam int EN_RX_BIT = 1;
	localparam int HALF_DUPLEX_BIT = 3;
	localparam int ERR_BREAK_BIT = 3;
	localparam int ERR_FRAME_BIT = 4;
	localparam int ERR_PARITY_BIT = 5;
	localparam int ERR_OVERRUN_BIT = 6;
	localparam int BREAK_LIVE_BIT = 7;

	localparam logic [1:0] PORT_ENABLE_RST = 2'h0;
	localparam logic [3:0] FLOW_MODE_RST = 4'h0;
	localparam logic [7:0] RESUME_CHAR_RST = 8'h11;
	localparam logic [7:0] PAUSE_CHAR_RST = 8'h13;
	localparam logic [3:0] ERROR_FLAGS_RST = 4'h0;

	typedef enum logic [2:0] {
		UFC_FLOW_NONE = 3'b000,
		UFC_FLOW_HW = 3'b001,
		UFC_FLOW_SW = 3'b010,
		UFC_FLOW_DROP_RX = 3'b011,
		UFC_FLOW_DROP_RXTX = 3'b100
	} ufc_flow_t;
endpackage : ufc_pkg

// File: core/ufc_char_match.sv
// ufc_char_match: compares a received character with a stored character at
// the configured width of 5 to 8 bits, or 9 bits with bit 8 taken as zero.
// assumes: inputs come from logic on the same clock; output is registered.
`timescale 1ns/1ps
`default_nettype none
module ufc_char_match (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [8:0] char_i,
	input wire logic [7:0] ref_i,
	input wire logic [1:0] width_sel_i,
	input wire logic nine_bit_i,
	output logic match_o
);
	logic [7:0] mask;
	logic next_match;

	// width_sel 0..3 selects 5..8 data bits
	assign mask = 8'hff >> (2'h3 - width_sel_i);
	// [RQ9]
	assign next_match = ((char_i[7:0] & mask) == (ref_i & mask))
		&& !(nine_bit_i && char_i[8]);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			match_o <= 1'b0;
		else
			match_o <= next_match;
	end
endmodule : ufc_char_match
`default_nettype wire

// File: test/ufc_node_model.sv
// ufc_node_model: remote serial node handing received characters and line state in.
// assumes: called from the bench; outputs change on the falling edge of clk_i.
`timescale 1ns/1ps
`default_nettype none
module ufc_node_model (
	input wire logic clk_i,
	output logic rx_char_valid_o,
	output logic [8:0] rx_char_o,
	output logic parity_err_o,
	output logic frame_err_o,
	output logic break_live_o
);
	initial
	begin
		rx_char_valid_o = 1'b0;
		rx_char_o = 9'h1aa;
		parity_err_o = 1'b1;
		frame_err_o = 1'b1;
		break_live_o = 1'b0;
	end
	// data and qualifiers invert once the pulse is over, so a stale value never passes
	task send(input logic [8:0] c, input logic p, input logic f);
		@(negedge clk_i);
		rx_char_valid_o = 1'b1;
		rx_char_o = c;
		parity_err_o = p;
		frame_err_o = f;
		@(negedge clk_i);
		rx_char_valid_o = 1'b0;
		rx_char_o = ~c;
		parity_err_o = ~p;
		frame_err_o = ~f;
	endtask : send
	task line_break(input logic on);
		@(negedge clk_i);
		break_live_o = on;
	endtask : line_break
endmodule : ufc_node_model
`default_nettype wire

// File: test/ufc_ctrl_tb.sv
// ufc_ctrl_tb: self-checking bench for the control and error-status block.
// assumes: ufc_pkg, ufc_ctrl and ufc_node_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module ufc_ctrl_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [9:0] addr = 10'h000;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] mask = 16'hffff;
	logic [1:0] width = 2'h3;
	logic nine = 1'b0;
	logic full = 1'b0;
	logic busy = 1'b0;
	logic [15:0] rdata;
	logic [8:0] ch;
	logic [2:0] mode;
	logic rvalid, txen, rxen, hwf, txa, rxa, push, ovr, cv, pe, fe, brk;
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;
	int pushes = 0;
	int ovrs = 0;
	ufc_ctrl u_ufc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
		.char_width_i(width), .nine_bit_i(nine), .rx_char_valid_i(cv), .rx_char_i(ch),
		.rx_fifo_full_i(full), .parity_err_i(pe), .frame_err_i(fe), .break_live_i(brk),
		.tx_busy_i(busy), .tx_enable_o(txen), .rx_enable_o(rxen), .flow_mode_o(mode),
		.hw_flow_o(hwf), .tx_allow_o(txa), .rx_accept_o(rxa), .rx_push_o(push),
		.overrun_o(ovr));
	ufc_node_model u_ufc_node_model (.clk_i(clk_i), .rx_char_valid_o(cv), .rx_char_o(ch),
		.parity_err_o(pe), .frame_err_o(fe), .break_live_o(brk));
	initial
	begin
		forever #50 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cyc++;
		if (push === 1'b1)
			pushes++;
		if (ovr === 1'b1)
			ovrs++;
		if (cyc == 3000)
		begin
			n_fail++;
			results();
		end
	end
	task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task wreg(input logic [9:0] a, input logic [15:0] d);
		@(negedge clk_i);
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge clk_i);
		wr = 1'b0;
	endtask : wreg
	task rreg(input logic [9:0] a, input logic [15:0] exp);
		@(negedge clk_i);
		rd = 1'b1;
		addr = a;
		@(negedge clk_i);
		rd = 1'b0;
		chk("rvalid", {15'h0, rvalid}, 16'h1);
		chk("rdata", rdata & mask, exp);
	endtask : rreg
	task rerr(input logic [15:0] exp);
		rreg(ufc_pkg::ADDR_ERROR_FLAGS, exp);
	endtask : rerr
	// the port is switched off around every configuration write, as hosts must do
	task cfg(input logic [15:0] fm, input logic [15:0] en);
		wreg(ufc_pkg::ADDR_PORT_ENABLE, 16'h0000);
		wreg(ufc_pkg::ADDR_FLOW_MODE, fm);
		wreg(ufc_pkg::ADDR_PORT_ENABLE, en);
		repeat (3) @(negedge clk_i);
	endtask : cfg
	task snd(input logic [8:0] c, input logic p, input logic f);
		u_ufc_node_model.send(c, p, f);
		repeat (4) @(negedge clk_i);
	endtask : snd
	task t_reset;
		rreg(ufc_pkg::ADDR_PORT_ENABLE, 16'h0000);
		rreg(ufc_pkg::ADDR_FLOW_MODE, 16'h0000);
		rreg(ufc_pkg::ADDR_RESUME_CHAR, 16'h0011);
		rreg(ufc_pkg::ADDR_PAUSE_CHAR, 16'h0013);
		rerr(16'h0000);
		rreg(10'h001, 16'h0000);
		wreg(ufc_pkg::ADDR_PORT_ENABLE, 16'h0001);
		@(negedge clk_i);
		chk("enables", {14'h0, rxen, txen}, 16'h0001);
		rreg(ufc_pkg::ADDR_PORT_ENABLE, 16'h0001);
	endtask : t_reset
	task t_errors;
		cfg(16'h0000, 16'h0002);
		snd(9'h041, 1'b1, 1'b0);
		rerr(16'h0020);
		rerr(16'h0000);
		snd(9'h042, 1'b0, 1'b1);
		snd(9'h043, 1'b1, 1'b0);
		rerr(16'h0030);
		full = 1'b1;
		pushes = 0;
		snd(9'h044, 1'b0, 1'b0);
		full = 1'b0;
		chk("push", 16'(pushes), 16'h0000);
		chk("overrun", 16'(ovrs), 16'h0001);
		rerr(16'h0040);
		u_ufc_node_model.line_break(1'b1);
		repeat (4) @(negedge clk_i);
		rerr(16'h0088);
		mask = 16'hfff7;
		rerr(16'h0080);
		u_ufc_node_model.line_break(1'b0);
		repeat (4) @(negedge clk_i);
		rerr(16'h0000);
		mask = 16'hffff;
		rerr(16'h0000);
	endtask : t_errors
	task t_half;
		cfg(16'h0008, 16'h0003);
		pushes = 0;
		busy = 1'b1;
		snd(9'h055, 1'b1, 1'b0);
		busy = 1'b0;
		chk("push", 16'(pushes), 16'h0000);
		rerr(16'h0000);
		snd(9'h056, 1'b1, 1'b0);
		chk("push", 16'(pushes), 16'h0001);
		rerr(16'h0020);
	endtask : t_half
	// a flag raised in the cycle of the clearing read must survive it
	task t_same;
		fork
			u_ufc_node_model.send(9'h041, 1'b1, 1'b0);
			rerr(16'h0000);
		join
		rerr(16'h0020);
	endtask : t_same
	task t_soft;
		cfg(16'h0002, 16'h0003);
		chk("allow", {15'h0, txa}, 16'h1);
		snd(9'h013, 1'b0, 1'b0);
		chk("allow", {15'h0, txa}, 16'h0);
		snd(9'h011, 1'b0, 1'b0);
		chk("allow", {15'h0, txa}, 16'h1);
		snd(9'h0f3, 1'b0, 1'b0);
		chk("allow", {15'h0, txa}, 16'h1);
		width = 2'h0;
		snd(9'h0f3, 1'b0, 1'b0);
		chk("allow", {15'h0, txa}, 16'h0);
		width = 2'h3;
		cfg(16'h0001, 16'h0003);
		chk("hw", {12'h0, hwf, mode}, 16'h0009);
	endtask : t_soft
	task t_drop;
		nine = 1'b1;
		cfg(16'h0003, 16'h0003);
		chk("gate", {14'h0, txa, rxa}, 16'h0002);
		pushes = 0;
		snd(9'h041, 1'b0, 1'b0);
		chk("push", 16'(pushes), 16'h0000);
		snd(9'h111, 1'b0, 1'b0);
		chk("gate", {14'h0, txa, rxa}, 16'h0003);
		snd(9'h041, 1'b0, 1'b0);
		chk("push", 16'(pushes), 16'h0001);
		snd(9'h155, 1'b0, 1'b0);
		chk("gate", {14'h0, txa, rxa}, 16'h0002);
		snd(9'h113, 1'b0, 1'b0);
		chk("gate", {14'h0, txa, rxa}, 16'h0003);
		cfg(16'h0004, 16'h0003);
		chk("gate", {14'h0, txa, rxa}, 16'h0000);
		snd(9'h111, 1'b0, 1'b0);
		chk("gate", {14'h0, txa, rxa}, 16'h0003);
		nine = 1'b0;
	endtask : t_drop
	// new characters take effect, then a mid-run reset restores the defaults
	task t_rst2;
		wreg(ufc_pkg::ADDR_PORT_ENABLE, 16'h0000);
		wreg(ufc_pkg::ADDR_RESUME_CHAR, 16'h005a);
		wreg(ufc_pkg::ADDR_PAUSE_CHAR, 16'h00a5);
		rreg(ufc_pkg::ADDR_RESUME_CHAR, 16'h005a);
		rreg(ufc_pkg::ADDR_PAUSE_CHAR, 16'h00a5);
		cfg(16'h0002, 16'h0003);
		snd(9'h0a5, 1'b0, 1'b0);
		chk("allow", {15'h0, txa}, 16'h0);
		snd(9'h05a, 1'b0, 1'b0);
		chk("allow", {15'h0, txa}, 16'h1);
		@(negedge clk_i);
		rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		chk("enables", {14'h0, rxen, txen}, 16'h0000);
		rreg(ufc_pkg::ADDR_RESUME_CHAR, 16'h0011);
		rreg(ufc_pkg::ADDR_PAUSE_CHAR, 16'h0013);
	endtask : t_rst2
	task results;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results
	initial
	begin
		repeat (8) @(negedge clk_i);
		rst_i = 1'b0;
		t_reset();
		t_errors();
		t_half();
		t_same();
		t_soft();
		t_drop();
		t_rst2();
		results();
	end
endmodule : ufc_ctrl_tb
`default_nettype wire
